/* hdl/ext_bus_interface.sv */
// External memory bus interface with an AHB-Lite register port
// Function
// - Drive 24-bit address during external accesses
// - 16-bit data bus, driven only on writes
// - Low write strobe writes data bits 7:0
// - High write strobe writes bits 15:8 independently
// - Direction high on read or dummy, low write
// - Visible mode strobes read on internal reads
// - Master requests bus; device floats pins and grants on the same edge
// - Wait input honoured only in N modes
// - Dynamic sizing of 8 and 16-bit devices
// - System clock out is oscillator divided two
// - Clock out divided four, high in reset
`include "ext_bus_cfg.svh"

module ext_bus_interface (
    // Clock (oscillator) and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Address bus
    output logic [23:0] address_out,
    output logic address_oe_n,
    // Data bus
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe_n,
    // Strobes and direction
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic high_byte_write_strobe_n,
    output logic direction_out,
    output logic control_oe_n,
    // Wait, strap and bus handshake
    input wire logic wait_request_n,
    input wire logic bus_width_strap,
    input wire logic bus_request_in_n,
    output logic bus_grant_out_n,
    // Divided clocks
    output logic system_clock_out,
    output logic clock_out_div4
);

    // --------
    // State
    // --------

    // All registered state of the interface
    typedef struct packed {
        ext_bus_pkg::cycle_state_type state;
        logic dp_write;           // Data phase of a write pending
        logic [7:0] dp_addr;      // Its offset
        logic [1:0] wait_mode;    // Wait mode setting
        logic visible;            // Internal reads show the read strobe
        logic narrow;             // Current device is 8 bits wide
        logic [23:0] acc_addr;    // Access address
        logic [15:0] acc_wdata;   // Write data
        logic cmd_write;          // Access is a write
        logic cmd_word;           // Access is a 16-bit word
        logic cmd_internal;       // Access targets an internal area
        logic busy;               // Access pending or running
        logic done;               // Sticky completion flag
        logic second;             // Second byte of a split word
        logic [1:0] wait_cnt;     // Strobe cycles counted
        logic [15:0] rdata;       // Read result
        logic strap_taken;        // Strap sampled once
        logic strap;              // Sampled strap level
        logic [31:0] hrdata;
        logic hreadyout;
        logic [23:0] addr_out;
        logic addr_oe_n;
        logic [15:0] data_out;
        logic data_oe_n;
        logic rd_n;
        logic wr_n;
        logic wrh_n;
        logic dir;
        logic ctl_oe_n;
    } main_type;

    main_type st_ff;
    main_type nxt_st;

    logic float_bus;     // Order to float all pins
    logic eight_bit;     // Access goes over an 8-bit path
    logic [1:0] base_wait;
    logic honour_wait;
    logic addr_phase;

    // --------
    // Helpers
    // --------

    // Register offset match on a byte address
    function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
        hits = (a == off);
    endfunction

    // Fixed strobe cycles before the wait input is looked at
    assign base_wait = (st_ff.wait_mode == `WAIT_ONE || st_ff.wait_mode == `WAIT_ONE_N)
        ? `ONE_CNT : `ZERO_CNT;
    // Wait input only counts in the two N modes
    assign honour_wait = (st_ff.wait_mode == `WAIT_ONE_N)
        || (st_ff.wait_mode == `WAIT_ZERO_N);
    // Strap high forces 8 bits; otherwise the device setting decides
    assign eight_bit = st_ff.strap | st_ff.narrow;
    assign addr_phase = hsel && htrans[`HTRANS_ACTIVE] && hready;

    // Release handshake
    bus_release u_release (
        .hclk(hclk),
        .hresetn(hresetn),
        .bus_request_in_n(bus_request_in_n),
        .bus_free(st_ff.state == ext_bus_pkg::ST_IDLE),
        .float_bus(float_bus),
        .bus_grant_out_n(bus_grant_out_n)
    );

    // Divided clocks
    clock_divider u_clocks (
        .hclk(hclk),
        .hresetn(hresetn),
        .system_clock_out(system_clock_out),
        .clock_out_div4(clock_out_div4)
    );

    // --------
    // Next state
    // --------

    // Register port and external cycle engine
    always_comb begin
        nxt_st = st_ff;
        nxt_st.hreadyout = 1'b1;
        // Strap caught once after reset release
        if (!st_ff.strap_taken) begin
            nxt_st.strap_taken = 1'b1;
            nxt_st.strap = bus_width_strap;
        end
        // Write data phase
        nxt_st.dp_write = 1'b0;
        if (st_ff.dp_write) begin
            if (hits(st_ff.dp_addr, `OFF_CTRL)) begin
                nxt_st.wait_mode = hwdata[`CTRL_WAIT_HI:`CTRL_WAIT_LO];
                nxt_st.visible = hwdata[`CTRL_VISIBLE];
                nxt_st.narrow = hwdata[`CTRL_NARROW];
            end
            if (hits(st_ff.dp_addr, `OFF_ADDR) && !st_ff.busy) begin
                nxt_st.acc_addr = hwdata[23:0];
            end
            if (hits(st_ff.dp_addr, `OFF_WDATA) && !st_ff.busy) begin
                nxt_st.acc_wdata = hwdata[15:0];
            end
            if (hits(st_ff.dp_addr, `OFF_STATUS) && hwdata[`STAT_DONE]) begin
                nxt_st.done = 1'b0;
            end
            if (hits(st_ff.dp_addr, `OFF_CMD) && !st_ff.busy) begin
                nxt_st.cmd_write = hwdata[`CMD_WRITE];
                nxt_st.cmd_word = hwdata[`CMD_WORD];
                nxt_st.cmd_internal = hwdata[`CMD_INTERNAL];
                nxt_st.busy = 1'b1;
            end
        end
        // Address phase: reads answered at the next edge
        if (addr_phase) begin
            nxt_st.dp_write = hwrite;
            nxt_st.dp_addr = haddr[7:0];
            if (!hwrite) begin
                if (hits(haddr[7:0], `OFF_CTRL)) begin
                    nxt_st.hrdata = {28'h000_0000, st_ff.narrow, st_ff.visible, st_ff.wait_mode};
                end else if (hits(haddr[7:0], `OFF_ADDR)) begin
                    nxt_st.hrdata = {`ZERO_BYTE, st_ff.acc_addr};
                end else if (hits(haddr[7:0], `OFF_WDATA)) begin
                    nxt_st.hrdata = {`ZERO_HALF, st_ff.acc_wdata};
                end else if (hits(haddr[7:0], `OFF_CMD)) begin
                    nxt_st.hrdata = {29'h0000_0000, st_ff.cmd_internal, st_ff.cmd_word,
                        st_ff.cmd_write};
                end else if (hits(haddr[7:0], `OFF_STATUS)) begin
                    nxt_st.hrdata = {28'h000_0000, st_ff.strap, ~bus_grant_out_n,
                        st_ff.done, st_ff.busy};
                end else if (hits(haddr[7:0], `OFF_RDATA)) begin
                    nxt_st.hrdata = {`ZERO_HALF, st_ff.rdata};
                end else begin
                    nxt_st.hrdata = `ZERO_WORD;
                end
            end
        end
        // External bus cycle engine
        case (st_ff.state)
            // Between cycles: dummy level on direction
            ext_bus_pkg::ST_IDLE: begin
                nxt_st.dir = 1'b1;
                if (st_ff.busy && !float_bus && bus_request_in_n) begin
                    nxt_st.state = ext_bus_pkg::ST_SETUP;
                    nxt_st.second = 1'b0;
                end
            end
            // Put address, direction and write data out
            ext_bus_pkg::ST_SETUP: begin
                nxt_st.addr_out = st_ff.second
                    ? (st_ff.acc_addr + `ONE_ADDR) : st_ff.acc_addr;
                nxt_st.dir = ~st_ff.cmd_write;
                nxt_st.data_oe_n = ~st_ff.cmd_write | st_ff.cmd_internal;
                nxt_st.wait_cnt = `ZERO_CNT;
                nxt_st.state = ext_bus_pkg::ST_STROBE;
                if (!st_ff.cmd_write) begin
                    // Read strobe; internal reads only in visible mode
                    nxt_st.rd_n = st_ff.cmd_internal && !st_ff.visible;
                end else if (!st_ff.cmd_internal) begin
                    if (st_ff.cmd_word && !eight_bit) begin
                        nxt_st.data_out = st_ff.acc_wdata;
                        nxt_st.wr_n = 1'b0;
                        nxt_st.wrh_n = 1'b0;
                    end else if (st_ff.cmd_word) begin
                        nxt_st.data_out = {`ZERO_BYTE, st_ff.second
                            ? st_ff.acc_wdata[15:8] : st_ff.acc_wdata[7:0]};
                        nxt_st.wr_n = 1'b0;
                    end else if (!eight_bit && st_ff.acc_addr[0]) begin
                        nxt_st.data_out = {st_ff.acc_wdata[7:0], `ZERO_BYTE};
                        nxt_st.wrh_n = 1'b0;
                    end else begin
                        nxt_st.data_out = {`ZERO_BYTE, st_ff.acc_wdata[7:0]};
                        nxt_st.wr_n = 1'b0;
                    end
                end
            end
            // Strobe held for the fixed waits, then, in the N modes, while wait is pulled
            ext_bus_pkg::ST_STROBE: begin
                if (st_ff.wait_cnt >= base_wait && (!honour_wait || wait_request_n)) begin
                    nxt_st.rd_n = 1'b1;
                    nxt_st.wr_n = 1'b1;
                    nxt_st.wrh_n = 1'b1;
                    nxt_st.state = ext_bus_pkg::ST_FINISH;
                    if (!st_ff.cmd_write && !st_ff.cmd_internal) begin
                        if (st_ff.cmd_word && !eight_bit) begin
                            nxt_st.rdata = data_in;
                        end else if (st_ff.cmd_word && st_ff.second) begin
                            nxt_st.rdata[15:8] = data_in[7:0];
                        end else if (!eight_bit && st_ff.acc_addr[0]) begin
                            nxt_st.rdata = {`ZERO_BYTE, data_in[15:8]};
                        end else begin
                            nxt_st.rdata = {st_ff.cmd_word ? st_ff.rdata[15:8] : `ZERO_BYTE,
                                data_in[7:0]};
                        end
                    end
                end else if (st_ff.wait_cnt != `MAX_CNT) begin
                    nxt_st.wait_cnt = st_ff.wait_cnt + `ONE_CNT;
                end
            end
            // Close the cycle or run the upper byte over 8 bits
            ext_bus_pkg::ST_FINISH: begin
                nxt_st.data_oe_n = 1'b1;
                nxt_st.dir = 1'b1;
                if (st_ff.cmd_word && eight_bit && !st_ff.second && !st_ff.cmd_internal) begin
                    nxt_st.second = 1'b1;
                    nxt_st.state = ext_bus_pkg::ST_SETUP;
                end else begin
                    nxt_st.busy = 1'b0;
                    nxt_st.done = 1'b1;
                    nxt_st.state = ext_bus_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_st.state = ext_bus_pkg::ST_IDLE;
            end
        endcase
        // Float every bus pin while the outside master owns the bus
        nxt_st.addr_oe_n = float_bus;
        nxt_st.ctl_oe_n = float_bus;
        if (float_bus) begin
            nxt_st.data_oe_n = 1'b1;
        end
    end

    // --------
    // Registers
    // --------

    // State register with reset values
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '{state: ext_bus_pkg::ST_IDLE, dp_write: 1'b0, dp_addr: `ZERO_BYTE,
                wait_mode: `WAIT_ZERO, visible: 1'b0, narrow: 1'b0, acc_addr: `ZERO_ADDR,
                acc_wdata: `ZERO_HALF, cmd_write: 1'b0, cmd_word: 1'b0,
                cmd_internal: 1'b0, busy: 1'b0, done: 1'b0, second: 1'b0,
                wait_cnt: `ZERO_CNT, rdata: `ZERO_HALF, strap_taken: 1'b0, strap: 1'b0,
                hrdata: `ZERO_WORD, hreadyout: 1'b1, addr_out: `ZERO_ADDR,
                addr_oe_n: 1'b0, data_out: `ZERO_HALF, data_oe_n: 1'b1, rd_n: 1'b1,
                wr_n: 1'b1, wrh_n: 1'b1, dir: 1'b1, ctl_oe_n: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // --------
    // Outputs
    // --------

    assign hreadyout = st_ff.hreadyout;
    assign hresp = 1'b0;
    assign hrdata = st_ff.hrdata;
    assign address_out = st_ff.addr_out;
    assign address_oe_n = st_ff.addr_oe_n;
    assign data_out = st_ff.data_out;
    assign data_oe_n = st_ff.data_oe_n;
    assign read_strobe_n = st_ff.rd_n;
    assign write_strobe_n = st_ff.wr_n;
    assign high_byte_write_strobe_n = st_ff.wrh_n;
    assign direction_out = st_ff.dir;
    assign control_oe_n = st_ff.ctl_oe_n;

endmodule // ext_bus_interface

/* hdl/ext_bus_cfg.svh */
// Constants of the external memory bus interface
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH

// --------
// Register byte offsets
// --------
`define OFF_CTRL 8'h00
`define OFF_ADDR 8'h04
`define OFF_WDATA 8'h08
`define OFF_CMD 8'h0C
`define OFF_STATUS 8'h10
`define OFF_RDATA 8'h14

// --------
// Control register fields
// --------
`define CTRL_WAIT_LO 0
`define CTRL_WAIT_HI 1
`define CTRL_VISIBLE 2
`define CTRL_NARROW 3

// --------
// Command register fields
// --------
`define CMD_WRITE 0
`define CMD_WORD 1
`define CMD_INTERNAL 2

// --------
// Status register fields
// --------
`define STAT_DONE 1

// --------
// Wait modes
// --------
`define WAIT_ZERO 2'h0
`define WAIT_ONE 2'h1
`define WAIT_ONE_N 2'h2
`define WAIT_ZERO_N 2'h3

// --------
// Reset values and small constants
// --------
`define ZERO_WORD 32'h0000_0000
`define ZERO_HALF 16'h0000
`define ZERO_ADDR 24'h00_0000
`define ONE_ADDR 24'h00_0001
`define ZERO_BYTE 8'h00
`define ZERO_CNT 2'h0
`define ONE_CNT 2'h1
`define MAX_CNT 2'h3
`define HTRANS_ACTIVE 1

`endif

/* hdl/ext_bus_pkg.sv */
// Types shared by the external memory bus interface modules
package ext_bus_pkg;

    // One-hot states of the external bus cycle engine
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_FINISH = 4'b1000
    } cycle_state_type;

    // One-hot states of the bus release handshake
    typedef enum logic [2:0] {
        AR_OWN = 3'b001,
        AR_FLOAT = 3'b010,
        AR_GRANT = 3'b100
    } arb_state_type;

endpackage

/* hdl/clock_divider.sv */
// Divided clock outputs derived from the oscillator clock
`include "ext_bus_cfg.svh"

module clock_divider (
    // Oscillator clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Divided clocks
    output logic system_clock_out,
    output logic clock_out_div4
);

    // All state of the divider
    typedef struct packed {
        logic half;
        logic quarter;
    } div_type;

    div_type div_ff;
    div_type nxt_div;

    // Next state: half toggles each edge, quarter each second edge
    always_comb begin
        nxt_div = div_ff;
        nxt_div.half = ~div_ff.half;
        if (div_ff.half) begin
            nxt_div.quarter = ~div_ff.quarter;
        end
    end

    // Quarter clock rests high while reset is held
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_ff <= '{half: 1'b0, quarter: 1'b1};
        end else begin
            div_ff <= nxt_div;
        end
    end

    assign system_clock_out = div_ff.half;
    assign clock_out_div4 = div_ff.quarter;

endmodule // clock_divider

/* hdl/bus_release.sv */
// Bus request and grant handshake with an outside master
`include "ext_bus_cfg.svh"

module bus_release (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Request from the outside master and engine status
    input wire logic bus_request_in_n,
    input wire logic bus_free,
    // Float order to the engine and grant to the master
    output logic float_bus,
    output logic bus_grant_out_n
);

    // All state of the handshake
    typedef struct packed {
        ext_bus_pkg::arb_state_type state;
        logic float_bus;
        logic grant_n;
    } arb_type;

    arb_type arb_ff;
    arb_type nxt_arb;

    // Float first, grant one edge later, release once the request drops
    always_comb begin
        nxt_arb = arb_ff;
        case (arb_ff.state)
            // Accept a request only between bus cycles
            ext_bus_pkg::AR_OWN: begin
                if (!bus_request_in_n && bus_free) begin
                    nxt_arb.state = ext_bus_pkg::AR_FLOAT;
                    nxt_arb.float_bus = 1'b1;
                end
            end
            // Pins float at the same edge as this grant
            ext_bus_pkg::AR_FLOAT: begin
                nxt_arb.state = ext_bus_pkg::AR_GRANT;
                nxt_arb.grant_n = 1'b0;
            end
            // Hold until the master withdraws
            ext_bus_pkg::AR_GRANT: begin
                if (bus_request_in_n) begin
                    nxt_arb.state = ext_bus_pkg::AR_OWN;
                    nxt_arb.grant_n = 1'b1;
                    nxt_arb.float_bus = 1'b0;
                end
            end
            default: begin
                nxt_arb.state = ext_bus_pkg::AR_OWN;
                nxt_arb.grant_n = 1'b1;
                nxt_arb.float_bus = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arb_ff <= '{state: ext_bus_pkg::AR_OWN, float_bus: 1'b0, grant_n: 1'b1};
        end else begin
            arb_ff <= nxt_arb;
        end
    end

    assign float_bus = arb_ff.float_bus;
    assign bus_grant_out_n = arb_ff.grant_n;

endmodule // bus_release

/* tb/ext_bus_interface_monitor.sv */
// Checker of the external bus pins of the memory bus interface
module ext_bus_checker (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // External bus pins
    input wire logic [23:0] address_out,
    input wire logic address_oe_n,
    input wire logic data_oe_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic high_byte_write_strobe_n,
    input wire logic direction_out,
    input wire logic control_oe_n,
    // Handshake and clocks
    input wire logic bus_request_in_n,
    input wire logic bus_grant_out_n,
    input wire logic system_clock_out,
    input wire logic clock_out_div4
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic any_lo; // Some strobe is low
    assign any_lo = !read_strobe_n || !write_strobe_n || !high_byte_write_strobe_n;
    chk_div4_reset: assert property (disable iff (1'b0) !hresetn |-> clock_out_div4)
        else $error("clock out low in reset");
    chk_sysclk_half: assert property ($past(hresetn)
        |-> system_clock_out != $past(system_clock_out))
        else $error("system clock did not toggle");
    chk_div4_quarter: assert property ($past(hresetn) && $past(hresetn, 2)
        |-> clock_out_div4 != $past(clock_out_div4, 2))
        else $error("clock out not a quarter rate");
    chk_write_drives: assert property (
        !write_strobe_n || !high_byte_write_strobe_n |-> !direction_out && !data_oe_n)
        else $error("write without data drive or low direction");
    chk_read_floats: assert property (!read_strobe_n |-> direction_out && data_oe_n)
        else $error("read with data driven or low direction");
    chk_strobe_excl: assert property (!read_strobe_n
        |-> write_strobe_n && high_byte_write_strobe_n)
        else $error("read and write strobes together");
    chk_addr_hold: assert property (any_lo && $past(any_lo) |-> $stable(address_out))
        else $error("address moved under a strobe");
    chk_grant_float: assert property (!bus_grant_out_n
        |-> address_oe_n && data_oe_n && control_oe_n)
        else $error("pins driven while granted");
    chk_grant_hold: assert property (!bus_request_in_n && !bus_grant_out_n
        |=> !bus_grant_out_n)
        else $error("grant dropped under request");
    chk_grant_drop: assert property ($rose(bus_request_in_n) && !bus_grant_out_n
        |-> ##[1:2] bus_grant_out_n)
        else $error("grant not withdrawn");
    cover property (!high_byte_write_strobe_n && write_strobe_n);
    cover property (!read_strobe_n ##1 !read_strobe_n ##1 !read_strobe_n);
    cover property (!bus_grant_out_n);
endmodule // ext_bus_checker

bind ext_bus_interface ext_bus_checker chk_i (.hclk, .hresetn, .address_out, .address_oe_n,
    .data_oe_n, .read_strobe_n, .write_strobe_n, .high_byte_write_strobe_n, .direction_out,
    .control_oe_n, .bus_request_in_n, .bus_grant_out_n, .system_clock_out, .clock_out_div4);

/* tb/ext_memory_model.sv */
// Behavioural external memory with a wait source
module ext_memory_model (
    // Clock
    input wire logic hclk,
    // Device pins
    input wire logic [23:0] address_out,
    input wire logic [15:0] data_out,
    input wire logic data_oe_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic high_byte_write_strobe_n,
    // Wait cycles per strobe
    input wire logic [3:0] stall,
    // Resolved data wire and wait request
    output logic [15:0] data_in,
    output logic wait_request_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [32]; // Store indexed by low address bits
    logic [15:0] last = 16'h0000; // Last wire level
    logic [3:0] cnt = 4'h0; // Cycles since a strobe fell
    // Byte lanes land independently
    always @(posedge hclk) begin
        if (!write_strobe_n) mem[address_out[4:0]][7:0] <= data_out[7:0];
        if (!high_byte_write_strobe_n) mem[address_out[4:0]][15:8] <= data_out[15:8];
        cnt <= (read_strobe_n && write_strobe_n && high_byte_write_strobe_n) ? 4'h0 : cnt + 4'h1;
        last <= data_in;
    end
    // Wait held low for the first stall cycles of a strobe
    assign wait_request_n = (cnt >= stall);
    // Device drives on writes, memory on reads, else the wire drifts
    assign data_in = !data_oe_n ? data_out : (!read_strobe_n ? mem[address_out[4:0]] : ~last);
endmodule // ext_memory_model

/* tb/ext_bus_interface_bench.sv */
// Self-checking bench of the external memory bus interface
module ext_bus_interface_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic bus_width_strap = 1'b0;
    logic bus_request_in_n = 1'b1;
    logic [3:0] stall = 4'h2;
    logic hready, hresp, address_oe_n, data_oe_n, read_strobe_n, write_strobe_n;
    logic high_byte_write_strobe_n, direction_out, control_oe_n, wait_request_n;
    logic bus_grant_out_n, system_clock_out, clock_out_div4;
    logic [31:0] hrdata, r;
    logic [23:0] address_out;
    logic [15:0] data_in, data_out;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_lo, n_hi, n_rd; // Strobe low cycles since cleared
    // Design, hreadyout fed back as hready
    ext_bus_interface dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .address_out, .address_oe_n,
        .data_in, .data_out, .data_oe_n, .read_strobe_n, .write_strobe_n,
        .high_byte_write_strobe_n, .direction_out, .control_oe_n, .wait_request_n,
        .bus_width_strap, .bus_request_in_n, .bus_grant_out_n, .system_clock_out,
        .clock_out_div4);
    ext_memory_model mem_i (.hclk, .address_out, .data_out, .data_oe_n, .read_strobe_n,
        .write_strobe_n, .high_byte_write_strobe_n, .stall, .data_in, .wait_request_n);
    initial begin
        forever #4 hclk = ~hclk;
    end
    // Strobes counted mid-cycle, away from edges
    always @(negedge hclk) begin
        n_lo += !write_strobe_n;
        n_hi += !high_byte_write_strobe_n;
        n_rd += !read_strobe_n;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One AHB-Lite single transfer
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // Poll until done, then clear it
    task automatic wait_done;
        r = 32'h0000_0000;
        for (int i = 0; i < 60 && r[1] !== 1'b1; i++) bus(1'b0, 8'h10, 32'h0000_0000, r);
        check({31'h0000_0000, r[1]}, 32'h0000_0001, "done");
        bus(1'b1, 8'h10, 32'h0000_0002, r);
    endtask
    // External access, strobe counts checked as 0x00LLHHRR
    task automatic access(input logic [2:0] cmd, input logic [23:0] a, input logic [15:0] wd,
        input logic [31:0] strobes);
        bus(1'b1, 8'h04, {8'h00, a}, r);
        bus(1'b1, 8'h08, {16'h0000, wd}, r);
        n_lo = 0;
        n_hi = 0;
        n_rd = 0;
        bus(1'b1, 8'h0C, {29'h0000_0000, cmd}, r);
        wait_done();
        check(n_lo * 65536 + n_hi * 256 + n_rd, strobes, "strobes");
        bus(1'b0, 8'h14, 32'h0000_0000, r);
    endtask
    initial begin
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        check(clock_out_div4, 1'b1, "div4 in reset");
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        access(3'h1, 24'h00_0004, 16'h1234, 32'h0001_0000);
        access(3'h1, 24'h00_0005, 16'h5656, 32'h0000_0100);
        access(3'h0, 24'h00_0004, 16'h0000, 32'h0000_0001);
        check(r[7:0], 8'h34, "even byte");
        access(3'h0, 24'h00_0005, 16'h0000, 32'h0000_0001);
        check(r[7:0], 8'h56, "odd byte");
        access(3'h3, 24'h00_0020, 16'hBEEF, 32'h0001_0100);
        access(3'h2, 24'h00_0020, 16'h0000, 32'h0000_0001);
        check(r[15:0], 16'hBEEF, "word");
        $display("byte and word tests done");
        bus(1'b1, 8'h00, 32'h0000_0008, r);
        access(3'h3, 24'h00_0030, 16'hCAFE, 32'h0002_0000);
        access(3'h2, 24'h00_0030, 16'h0000, 32'h0000_0002);
        check(r[15:0], 16'hCAFE, "narrow word");
        $display("narrow test done");
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 8'h00, m, r);
            access(3'h1, 24'h00_0008, 16'h00A5, (1 + (m > 0) + (m > 1)) * 65536);
        end
        $display("wait mode test done");
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, 8'h00, m * 4, r);
            access(3'h4, 24'h00_0004, 16'h0000, m);
            access(3'h5, 24'h00_0004, 16'h0000, 32'h0000_0000);
        end
        $display("internal access test done");
        bus_request_in_n <= 1'b0;
        repeat (4) @(posedge hclk);
        check({bus_grant_out_n, address_oe_n, data_oe_n, control_oe_n}, 4'h7, "float");
        bus(1'b0, 8'h10, 32'h0000_0000, r);
        check(r[2], 1'b1, "granted");
        bus(1'b1, 8'h0C, 32'h0000_0001, r);
        n_lo = 0;
        repeat (6) @(posedge hclk);
        check(n_lo, 0, "held off");
        bus_request_in_n <= 1'b1;
        wait_done();
        check(n_lo, 1, "resumed");
        $display("bus release test done");
        hresetn <= 1'b0;
        bus_width_strap <= 1'b1;
        repeat (4) @(posedge hclk);
        check(clock_out_div4, 1'b1, "div4 in reset");
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        bus(1'b0, 8'h10, 32'h0000_0000, r);
        check(r[3], 1'b1, "strap");
        access(3'h3, 24'h00_0010, 16'h1357, 32'h0002_0000);
        $display("strap test done");
        end_of_test();
    end
    // Watchdog against a hang
    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
endmodule // ext_bus_interface_bench
